// ### velocity_mode_pkg.sv
// Summary of operation
// R1: standstill flag sets once 2^20 clocks pass after the last step pulse.
// R2: after standstill, wait delay times 2^18 clocks, then start current power down.
// R3: measure clocks between two 1/256 microsteps and expose it read only.
// R4: on counter overflow or standstill the interval reads as (2^20)-1.
// R5: interval at or above quiet threshold enables voltage pwm, blocks speed mode.
// R6: between high and load thresholds: load-adaptive current on, voltage pwm off.
// R7: interval at or below load threshold enables stop-on-stall and stall output.
// R8: interval at or below high threshold: load-adaptive off, voltage pwm off.
// R9: high region with chopper bit: force mode select 1, fast decay time 0.
// R10: high region with fullstep bit: fullstep, stall detection from speed mode.
// R11: fullstep entered only at 45 degrees, target current from table at 45.
// R12: during high velocity chopper switching the off time is doubled.
// R13: lower threshold uses raw interval, upper uses interval*15/16-1 or *31/32-1.
// R14: pwm enable turns on only at standstill; software sets it at standstill.
// R15: interval normalised to 256 microstep resolution whatever the microstep setting.
// R16: standstill flag selects hold current instead of run current.
// R17: comparisons re-run when a measurement completes or saturates, next cycle.
// R18: step source delivers single clean pulses synchronous to the clock.
`default_nettype none
package velocity_mode_pkg;
	localparam int          IVW            = 20;
	localparam logic [19:0] INTERVAL_MAX   = 20'hfffff;
	localparam int          STANDSTILL_CLK = 1048576;
	localparam int          PD_UNIT_CLK    = 262144;
	localparam int          MAX_SHIFT      = 8;
	// ******************************
	// register byte offsets
	// ******************************
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_CURRENT   = 8'h04;
	localparam logic [7:0] OFS_PD_DELAY  = 8'h08;
	localparam logic [7:0] OFS_INTERVAL  = 8'h0c;
	localparam logic [7:0] OFS_PWM_THR   = 8'h10;
	localparam logic [7:0] OFS_LOAD_THR  = 8'h14;
	localparam logic [7:0] OFS_HIGH_THR  = 8'h18;
	localparam logic [7:0] OFS_STATUS    = 8'h1c;
	localparam logic [7:0] OFS_IRQ_STAT  = 8'h20;
	localparam logic [7:0] OFS_IRQ_MASK  = 8'h24;
	// ******************************
	// field positions
	// ******************************
	localparam int CTRL_PWM_EN  = 0;
	localparam int CTRL_LOAD_EN = 1;
	localparam int CTRL_STALL   = 2;
	localparam int CTRL_SPEED   = 3;
	localparam int CTRL_SMALLH  = 4;
	localparam int CTRL_HFS     = 5;
	localparam int CTRL_HCHM    = 6;
	localparam int CTRL_SHIFT   = 8;
	localparam int CUR_HOLD     = 8;
	localparam int EV_STST      = 0;
	localparam int EV_HIGH      = 1;
	localparam int EV_PDOWN     = 2;
	localparam int NEV          = 3;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] CUR_RESET  = 32'h0000_101f;
	localparam logic [19:0] THR_RESET  = 20'h00000;
	localparam logic [7:0]  PD_RESET   = 8'h0a;
	typedef enum logic [1:0] {
		FS_MICRO   = 2'b00,
		FS_PENDING = 2'b01,
		FS_FULL    = 2'b10
	} fs_state_type;
	typedef struct packed {
		logic quiet_pwm;
		logic load_adapt;
		logic speed_mode;
		logic stall_stop;
		logic stall_out;
		logic chm_force;
		logic fast_decay_zero;
		logic off_time_double;
	} mode_flags_type;
endpackage : velocity_mode_pkg
`default_nettype wire

// ### velocity_mode_selector.sv
`default_nettype none
module velocity_mode_selector #(
	parameter int STANDSTILL_CYCLES = velocity_mode_pkg::STANDSTILL_CLK,
	parameter int PD_UNIT_CYCLES    = velocity_mode_pkg::PD_UNIT_CLK
) (
	input  wire logic                            hclk,
	input  wire logic                            hresetn,
	input  wire logic                            hsel,
	input  wire logic [31:0]                     haddr,
	input  wire logic [1:0]                      htrans,
	input  wire logic                            hwrite,
	input  wire logic [2:0]                      hsize,
	input  wire logic [31:0]                     hwdata,
	input  wire logic                            hready,
	output logic [31:0]                          hrdata,
	output logic                                 hreadyout,
	output logic                                 hresp,
	output logic                                 irq,
	input  wire logic                            step_pulse,
	input  wire logic                            at_45_deg,
	input  wire logic [7:0]                      table_current,
	output velocity_mode_pkg::mode_flags_type    modes,
	output logic                                 fullstep,
	output logic                                 stall_from_speed,
	output logic [7:0]                           fullstep_current,
	output logic                                 standstill,
	output logic                                 power_down,
	output logic [4:0]                           current_scale
);
	localparam logic [20:0] STST_CNT = 21'(STANDSTILL_CYCLES);
	localparam logic [17:0] PD_LAST  = 18'(PD_UNIT_CYCLES - 1);

	function automatic logic hit(input logic [19:0] v, input logic [19:0] t, input logic strict);
		hit = strict ? (v < t) : (v <= t);
	endfunction : hit

	// ******************************
	// register bus
	// ******************************
	logic [31:0] ctrl_reg;
	logic [31:0] cur_reg;
	logic [7:0]  pd_delay_reg;
	logic [19:0] pwm_thr_reg;
	logic [19:0] load_thr_reg;
	logic [19:0] high_thr_reg;
	logic [velocity_mode_pkg::NEV-1:0] irq_stat_reg;
	logic [velocity_mode_pkg::NEV-1:0] irq_mask_reg;
	logic        wr_pend_reg;
	logic [7:0]  wr_addr_reg;
	logic [31:0] hrdata_reg;
	logic        irq_reg;

	wire         addr_ok = hsel & hready & htrans[1];
	wire         wr_go   = wr_pend_reg;
	wire [7:0]   ra      = haddr[7:0];
	wire [velocity_mode_pkg::NEV-1:0] events;
	wire [velocity_mode_pkg::NEV-1:0] irq_clr =
		(wr_go && wr_addr_reg == velocity_mode_pkg::OFS_IRQ_STAT) ?
		hwdata[velocity_mode_pkg::NEV-1:0] : '0;
	wire [velocity_mode_pkg::NEV-1:0] irq_stat_next = events | (irq_stat_reg & ~irq_clr);

	// ******************************
	// step interval measurement
	// ******************************
	logic [20:0] since_step_reg;
	logic [19:0] interval_reg;
	logic        stst_reg;
	logic        eval_reg;

	wire [3:0]  shift_raw = ctrl_reg[velocity_mode_pkg::CTRL_SHIFT +: 4];
	wire [3:0]  shift     = (shift_raw > 4'(velocity_mode_pkg::MAX_SHIFT)) ?
		4'(velocity_mode_pkg::MAX_SHIFT) : shift_raw;
	// the taken edge itself belongs to the interval, so a period of n clocks reads n
	wire [20:0] elapsed   = since_step_reg + 21'h000001;
	wire [20:0] norm      = elapsed >> shift;
	wire        stst_hit  = !step_pulse && (since_step_reg == STST_CNT - 21'h000001);
	// a first pulse after standstill or past the counter top reports the saturated code
	wire        ovf       = stst_reg || norm[20] || since_step_reg >= STST_CNT;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			since_step_reg <= 21'h000000;
			stst_reg       <= 1'b1;
			interval_reg   <= velocity_mode_pkg::INTERVAL_MAX;
			eval_reg       <= 1'b0;
		end else begin
			eval_reg <= step_pulse | stst_hit; // R17
			if (step_pulse) begin // R18
				since_step_reg <= 21'h000000;
				stst_reg       <= 1'b0;
				interval_reg   <= ovf ? velocity_mode_pkg::INTERVAL_MAX : norm[19:0]; // R3 R4 R15
			end else begin
				// stops at its top so a long stop cannot wrap into a short interval
				if (since_step_reg != STST_CNT)
					since_step_reg <= since_step_reg + 21'h000001;
				if (stst_hit) begin
					stst_reg     <= 1'b1; // R1
					interval_reg <= velocity_mode_pkg::INTERVAL_MAX; // R4
				end
			end
		end
	end

	// ******************************
	// threshold comparison with hysteresis
	// ******************************
	// the reduced interval only decides whether a fast region is kept, so a jittery
	// measurement near a threshold cannot make the modes toggle
	wire        small_h = ctrl_reg[velocity_mode_pkg::CTRL_SMALLH];
	wire [19:0] hyst    = small_h ? (interval_reg >> 5) : (interval_reg >> 4);
	wire [19:0] part    = interval_reg - hyst;
	wire [19:0] reduced = (part == 20'h00000) ? 20'h00000 : part - 20'h00001; // R13
	wire [2:0][19:0] thr = {high_thr_reg, load_thr_reg, pwm_thr_reg};
	logic [2:0] fast_reg;

	// index 0 is the pwm limit and compares strictly, 1 the load limit, 2 the high limit
	for (genvar i = 0; i < 3; i++) begin : g_cmp
		wire strict = (i == 0);
		wire fast_next = fast_reg[i] ? hit(reduced, thr[i], strict) : hit(interval_reg, thr[i], strict); // R13
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn)
				fast_reg[i] <= 1'b0;
			else if (eval_reg)
				fast_reg[i] <= fast_next; // R17
		end
	end

	wire pwm_slow  = !fast_reg[0];
	wire load_zone = fast_reg[1];
	wire high_zone = fast_reg[2];

	// ******************************
	// mode enables
	// ******************************
	logic pwm_active_reg;
	velocity_mode_pkg::mode_flags_type modes_reg;
	wire  hchm = ctrl_reg[velocity_mode_pkg::CTRL_HCHM];
	velocity_mode_pkg::mode_flags_type modes_next;

	assign modes_next.quiet_pwm       = pwm_active_reg & pwm_slow & !load_zone & !high_zone; // R5 R6 R8
	assign modes_next.load_adapt      = ctrl_reg[velocity_mode_pkg::CTRL_LOAD_EN] & load_zone & !high_zone; // R6 R8
	assign modes_next.speed_mode      = ctrl_reg[velocity_mode_pkg::CTRL_SPEED] & !pwm_slow; // R5
	assign modes_next.stall_stop      = ctrl_reg[velocity_mode_pkg::CTRL_STALL] & load_zone; // R7
	assign modes_next.stall_out       = ctrl_reg[velocity_mode_pkg::CTRL_STALL] & load_zone; // R7
	assign modes_next.chm_force       = hchm & high_zone; // R9
	assign modes_next.fast_decay_zero = hchm & high_zone; // R9
	assign modes_next.off_time_double = hchm & high_zone; // R12

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pwm_active_reg <= 1'b0;
		else if (!ctrl_reg[velocity_mode_pkg::CTRL_PWM_EN])
			pwm_active_reg <= 1'b0;
		// switching on waits for standstill, so the chopper never changes over in mid move
		else if (stst_reg)
			pwm_active_reg <= 1'b1; // R14
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			modes_reg <= '0;
		else
			modes_reg <= modes_next;
	end

	// ******************************
	// fullstep switching
	// ******************************
	velocity_mode_pkg::fs_state_type fs_reg;
	velocity_mode_pkg::fs_state_type fs_next;
	logic [7:0] fs_cur_reg;
	wire  fs_req = ctrl_reg[velocity_mode_pkg::CTRL_HFS] & high_zone;

	always_comb begin
		fs_next = fs_reg;
		case (fs_reg)
			velocity_mode_pkg::FS_MICRO: begin
				if (fs_req)
					fs_next = at_45_deg ? velocity_mode_pkg::FS_FULL : velocity_mode_pkg::FS_PENDING;
			end
			velocity_mode_pkg::FS_PENDING: begin
				if (!fs_req)
					fs_next = velocity_mode_pkg::FS_MICRO;
				else if (at_45_deg)
					fs_next = velocity_mode_pkg::FS_FULL; // R11
			end
			velocity_mode_pkg::FS_FULL: begin
				// leaving also waits for 45 degrees so the coil currents stay continuous
				if (!fs_req && at_45_deg)
					fs_next = velocity_mode_pkg::FS_MICRO;
			end
			default: fs_next = velocity_mode_pkg::FS_MICRO;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fs_reg     <= velocity_mode_pkg::FS_MICRO;
			fs_cur_reg <= 8'h00;
		end else begin
			fs_reg <= fs_next; // R10
			// the table value at the 45 degree point becomes the fullstep target
			if (fs_reg != velocity_mode_pkg::FS_FULL && fs_next == velocity_mode_pkg::FS_FULL)
				fs_cur_reg <= table_current; // R11
		end
	end

	// ******************************
	// standstill power down
	// ******************************
	logic [17:0] pd_pre_reg;
	logic [7:0]  pd_cnt_reg;
	logic        pd_reg;
	logic        high_seen_reg;
	logic        stst_seen_reg;
	wire         pd_tick = (pd_pre_reg == PD_LAST);
	// a step in the same cycle wins, so power down never starts while the motor moves
	wire         pd_due  = stst_reg && !step_pulse && !pd_reg && pd_cnt_reg == pd_delay_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pd_pre_reg <= 18'h00000;
			pd_cnt_reg <= 8'h00;
			pd_reg     <= 1'b0;
		end else if (!stst_reg || step_pulse) begin
			pd_pre_reg <= 18'h00000;
			pd_cnt_reg <= 8'h00;
			pd_reg     <= 1'b0;
		end else if (pd_due) begin
			pd_reg <= 1'b1; // R2
		end else if (!pd_reg) begin
			pd_pre_reg <= pd_tick ? 18'h00000 : pd_pre_reg + 18'h00001;
			if (pd_tick)
				pd_cnt_reg <= pd_cnt_reg + 8'h01; // R2
		end
	end

	// ******************************
	// events and outputs
	// ******************************
	assign events[velocity_mode_pkg::EV_STST]  = stst_reg & !stst_seen_reg;
	assign events[velocity_mode_pkg::EV_HIGH]  = high_zone & !high_seen_reg;
	assign events[velocity_mode_pkg::EV_PDOWN] = pd_due;

	wire [31:0] status_word = {
		22'h000000,
		fs_reg == velocity_mode_pkg::FS_FULL,
		pwm_active_reg,
		modes_reg.quiet_pwm,
		modes_reg.load_adapt,
		high_zone,
		load_zone,
		pwm_slow,
		pd_reg,
		1'b0,
		stst_reg
	};

	wire [31:0] rd_mux =
		(ra == velocity_mode_pkg::OFS_CTRL)     ? ctrl_reg :
		(ra == velocity_mode_pkg::OFS_CURRENT)  ? cur_reg :
		(ra == velocity_mode_pkg::OFS_PD_DELAY) ? {24'h000000, pd_delay_reg} :
		(ra == velocity_mode_pkg::OFS_INTERVAL) ? {12'h000, interval_reg} :
		(ra == velocity_mode_pkg::OFS_PWM_THR)  ? {12'h000, pwm_thr_reg} :
		(ra == velocity_mode_pkg::OFS_LOAD_THR) ? {12'h000, load_thr_reg} :
		(ra == velocity_mode_pkg::OFS_HIGH_THR) ? {12'h000, high_thr_reg} :
		(ra == velocity_mode_pkg::OFS_STATUS)   ? status_word :
		(ra == velocity_mode_pkg::OFS_IRQ_STAT) ? {29'h00000000, irq_stat_reg} :
		(ra == velocity_mode_pkg::OFS_IRQ_MASK) ? {29'h00000000, irq_mask_reg} : 32'h00000000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg  <= 1'b0;
			wr_addr_reg  <= 8'h00;
			hrdata_reg   <= 32'h00000000;
			ctrl_reg     <= velocity_mode_pkg::CTRL_RESET;
			cur_reg      <= velocity_mode_pkg::CUR_RESET;
			pd_delay_reg <= velocity_mode_pkg::PD_RESET;
			pwm_thr_reg  <= velocity_mode_pkg::THR_RESET;
			load_thr_reg <= velocity_mode_pkg::THR_RESET;
			high_thr_reg <= velocity_mode_pkg::THR_RESET;
			irq_mask_reg <= '0;
		end else begin
			wr_pend_reg <= addr_ok & hwrite;
			if (addr_ok)
				wr_addr_reg <= ra;
			if (addr_ok & !hwrite)
				hrdata_reg <= rd_mux;
			if (wr_go) begin
				case (wr_addr_reg)
					velocity_mode_pkg::OFS_CTRL:     ctrl_reg     <= {20'h00000, hwdata[11:8], 1'b0, hwdata[6:0]};
					velocity_mode_pkg::OFS_CURRENT:  cur_reg      <= {19'h00000, hwdata[12:8], 3'h0, hwdata[4:0]};
					velocity_mode_pkg::OFS_PD_DELAY: pd_delay_reg <= hwdata[7:0];
					velocity_mode_pkg::OFS_PWM_THR:  pwm_thr_reg  <= hwdata[19:0];
					velocity_mode_pkg::OFS_LOAD_THR: load_thr_reg <= hwdata[19:0];
					velocity_mode_pkg::OFS_HIGH_THR: high_thr_reg <= hwdata[19:0];
					velocity_mode_pkg::OFS_IRQ_MASK: irq_mask_reg <= hwdata[velocity_mode_pkg::NEV-1:0];
					// read-only and unmapped offsets ignore writes
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_stat_reg  <= '0;
			irq_reg       <= 1'b0;
			high_seen_reg <= 1'b0;
			stst_seen_reg <= 1'b1;
		end else begin
			irq_stat_reg  <= irq_stat_next; // set wins over a same-cycle clear
			// built from the next status, so the pin rises together with its bit
			irq_reg       <= |(irq_stat_next & irq_mask_reg);
			high_seen_reg <= high_zone;
			stst_seen_reg <= stst_reg;
		end
	end

	// one cycle late against standstill, the price of a pin driven from a flop
	logic [4:0] cur_sel_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cur_sel_reg <= 5'h00;
		else
			cur_sel_reg <= stst_reg ? cur_reg[velocity_mode_pkg::CUR_HOLD +: 5] : cur_reg[4:0]; // R16
	end

	assign hrdata           = hrdata_reg;
	// zero wait states: every register answers in its data phase
	assign hreadyout        = 1'b1;
	assign hresp            = 1'b0;
	assign irq              = irq_reg;
	assign modes            = modes_reg;
	// the full step state alone has bit 1 of the code set, so both pins come from the state flop
	assign fullstep         = fs_reg[1];
	assign stall_from_speed = fs_reg[1]; // R10
	assign fullstep_current = fs_cur_reg;
	assign standstill       = stst_reg;
	assign power_down       = pd_reg;
	assign current_scale    = cur_sel_reg;
endmodule : velocity_mode_selector
`default_nettype wire

// ### velocity_mode_selector_chk.sv
`default_nettype none
module velocity_mode_selector_chk #(
	parameter int STANDSTILL_CYCLES = 64,
	parameter int PD_UNIT_CYCLES    = 8
) (
	input wire logic                              hclk,
	input wire logic                              hresetn,
	input wire logic                              step_pulse,
	input wire logic                              at_45_deg,
	input wire logic [7:0]                        table_current,
	input wire velocity_mode_pkg::mode_flags_type modes,
	input wire logic                              fullstep,
	input wire logic                              stall_from_speed,
	input wire logic [7:0]                        fullstep_current,
	input wire logic                              standstill,
	input wire logic                              power_down
);
	logic [31:0] idle_reg;
	// saturating, so a long stop never wraps back under the limit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idle_reg <= 32'h0;
		end else if (step_pulse) begin
			idle_reg <= 32'h0;
		end else if (idle_reg != 32'hffff_ffff) begin
			idle_reg <= idle_reg + 32'h1;
		end
	end
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// one cycle of slack: the flag is registered at the limit edge
	a_stst_after_idle: assert property (idle_reg > 32'(STANDSTILL_CYCLES) |-> standstill)
		else $error("standstill missing after idle time");
	a_stst_step_clear: assert property (step_pulse |=> !standstill)
		else $error("standstill kept after a step");
	a_pd_after_stst: assert property ($rose(power_down) |-> $past(standstill) && standstill)
		else $error("power down without standstill");
	a_pwm_load_excl: assert property (!(modes.quiet_pwm && modes.load_adapt))
		else $error("voltage pwm together with load adaption");
	a_high_zone_off: assert property (modes.chm_force |-> !modes.load_adapt && !modes.quiet_pwm)
		else $error("high zone with load adaption or pwm");
	a_chm_group: assert property (modes.chm_force == modes.fast_decay_zero && modes.off_time_double == modes.chm_force)
		else $error("chopper switch flags disagree");
	a_stall_pair: assert property (modes.stall_stop == modes.stall_out)
		else $error("stall stop and stall output differ");
	a_fs_entry: assert property ($rose(fullstep) |-> $past(at_45_deg) && fullstep_current == $past(table_current))
		else $error("fullstep entry off the 45 degree point");
	a_fs_stall_src: assert property (fullstep == stall_from_speed)
		else $error("stall source not following fullstep");
endmodule : velocity_mode_selector_chk
bind velocity_mode_selector velocity_mode_selector_chk #(
	.STANDSTILL_CYCLES(STANDSTILL_CYCLES),
	.PD_UNIT_CYCLES(PD_UNIT_CYCLES)
) chk_i (.hclk, .hresetn, .step_pulse, .at_45_deg, .table_current, .modes, .fullstep,
	.stall_from_speed, .fullstep_current, .standstill, .power_down);
`default_nettype wire

// ### step_source.sv
`default_nettype none
module step_source (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       run,
	input  wire logic [7:0] period,
	output logic            step_pulse,
	output logic            at_45_deg,
	output logic [7:0]      table_current
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt_reg;
	logic [7:0] pos_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_reg <= 8'h00;
			pos_reg <= 8'h00;
			step_pulse <= 1'b0;
		end else begin
			step_pulse <= run && cnt_reg >= period - 8'h1;
			cnt_reg <= (run && cnt_reg < period - 8'h1) ? cnt_reg + 8'h1 : 8'h00;
			pos_reg <= pos_reg + {7'h0, step_pulse};
		end
	end
	// 45 degrees every fourth step; table value moves so a stale latch shows
	assign at_45_deg = pos_reg[1:0] == 2'b01;
	assign table_current = 8'hb0 + pos_reg;
endmodule : step_source
`default_nettype wire

// ### velocity_mode_selector_tb.sv
`default_nettype none
module velocity_mode_selector_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] CTRL_BASE = 32'h66;
	logic        hclk, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, run = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, v;
	logic [1:0]  htrans = 2'b00;
	logic [2:0]  hsize = 3'b010;
	logic [7:0]  period = 8'd20, table_current, fullstep_current;
	logic        hreadyout, hresp, irq, step_pulse, at_45_deg, fullstep, stall_from_speed;
	logic        standstill, power_down;
	logic [4:0]  current_scale;
	velocity_mode_pkg::mode_flags_type modes;
	int          n_fail = 0, n_checks = 0, cnt, p, idle_cnt;
	logic [7:0]  rst_addr [8] = '{velocity_mode_pkg::OFS_CTRL, velocity_mode_pkg::OFS_CURRENT,
		velocity_mode_pkg::OFS_PD_DELAY, velocity_mode_pkg::OFS_INTERVAL, velocity_mode_pkg::OFS_PWM_THR,
		velocity_mode_pkg::OFS_LOAD_THR, velocity_mode_pkg::OFS_HIGH_THR, 8'h40};
	logic [31:0] rst_val [8] = '{32'h0, 32'h101f, 32'h0a, 32'hfffff, 32'h0, 32'h0, 32'h0, 32'h0};
	velocity_mode_selector #(.STANDSTILL_CYCLES(64), .PD_UNIT_CYCLES(8)) uut (.hclk, .hresetn, .hsel,
		.haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq,
		.step_pulse, .at_45_deg, .table_current, .modes, .fullstep, .stall_from_speed, .fullstep_current,
		.standstill, .power_down, .current_scale);
	step_source src (.hclk, .hresetn, .run, .period, .step_pulse, .at_45_deg, .table_current);
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	// clocks since the last step the design took, independent of bus traffic
	always @(posedge hclk) idle_cnt <= (step_pulse === 1'b1) ? 0 : idle_cnt + 1;
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			chk("bus wait", 32'h1, 32'h0);
			final_report();
		end
	endtask : wait_ready
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= wr;
		wait_ready();
		htrans <= 2'b00;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
		chk("response", 32'h0, {31'h0, hresp});
	endtask : bus
	task automatic wait_pulses(input int k);
		int n;
		n = 0;
		while (k > 0 && n < 1000) begin
			@(posedge hclk);
			n++;
			if (step_pulse === 1'b1) k--;
		end
		if (k > 0) begin
			chk("pulse wait", 32'h1, 32'h0);
			final_report();
		end
	endtask : wait_pulses
	// four pulses: the first may carry a half-old period
	task automatic run_at(input logic [7:0] per, input logic [7:0] exp, input string what);
		period <= per;
		wait_pulses(4);
		chk(what, {24'h0, exp}, {24'h0, modes});
	endtask : run_at
	function automatic logic [31:0] exp_interval(input int per, input int shift);
		return 32'(per >> shift);
	endfunction : exp_interval
	function automatic int exp_pd(input int d);
		return d * 8;
	endfunction : exp_pd
	initial begin
		repeat (60000) @(posedge hclk);
		chk("run time", 32'h1, 32'h0);
		final_report();
	end
	initial begin
		void'($urandom(32'h8e4a));
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		#1;
		chk("hold scale", 32'd16, {27'h0, current_scale});
		@(posedge hclk);
		foreach (rst_addr[i]) begin
			bus(1'b0, rst_addr[i], 32'h0);
			chk("reset value", rst_val[i], rd);
		end
		for (int i = 4; i < 7; i++) begin
			v = $urandom & 32'hfffff;
			bus(1'b1, rst_addr[i], v);
			bus(1'b0, rst_addr[i], 32'h0);
			chk("threshold", v, rd);
		end
		bus(1'b1, velocity_mode_pkg::OFS_INTERVAL, 32'h0);
		bus(1'b0, velocity_mode_pkg::OFS_INTERVAL, 32'h0);
		chk("interval ro", 32'hfffff, rd);
		bus(1'b1, velocity_mode_pkg::OFS_PWM_THR, 32'd30);
		bus(1'b1, velocity_mode_pkg::OFS_LOAD_THR, 32'd40);
		bus(1'b1, velocity_mode_pkg::OFS_HIGH_THR, 32'd10);
		bus(1'b1, velocity_mode_pkg::OFS_PD_DELAY, 32'd2);
		for (int s = 0; s <= 4; s += 2) begin
			p = 24 + $urandom_range(31, 0);
			bus(1'b1, velocity_mode_pkg::OFS_CTRL, CTRL_BASE | 32'(s << 8));
			period <= 8'(p);
			run <= 1'b1;
			wait_pulses(3);
			bus(1'b0, velocity_mode_pkg::OFS_INTERVAL, 32'h0);
			chk("interval", exp_interval(p, s), rd);
		end
		bus(1'b1, velocity_mode_pkg::OFS_CTRL, CTRL_BASE);
		run_at(8'd20, 8'h58, "load zone");
		chk("run scale", 32'd31, {27'h0, current_scale});
		run_at(8'd8, 8'h1f, "high zone");
		cnt = 0;
		while (fullstep !== 1'b1 && cnt < 100) begin
			@(posedge hclk);
			cnt++;
		end
		chk("fullstep", 32'h1, {31'h0, fullstep});
		run_at(8'd11, 8'h1f, "high hold");
		run_at(8'd12, 8'h58, "high exit");
		bus(1'b1, velocity_mode_pkg::OFS_CTRL, CTRL_BASE | 32'h18);
		run_at(8'd12, 8'h78, "speed mode");
		run_at(8'd43, 8'h00, "narrow hysteresis");
		bus(1'b1, velocity_mode_pkg::OFS_CTRL, CTRL_BASE | 32'h1);
		run_at(8'd50, 8'h00, "pwm on while running");
		bus(1'b1, velocity_mode_pkg::OFS_CTRL, CTRL_BASE);
		run <= 1'b0;
		cnt = 0;
		while (standstill !== 1'b1 && cnt < 200) begin
			@(posedge hclk);
			cnt++;
		end
		chk("standstill time", 32'h1, {31'h0, idle_cnt >= 64 && idle_cnt <= 66});
		cnt = 0;
		while (power_down !== 1'b1 && cnt < 200) begin
			@(posedge hclk);
			cnt++;
		end
		chk("power down time", 32'h1, {31'h0, cnt >= exp_pd(2) - 1 && cnt <= exp_pd(2) + 2});
		bus(1'b0, velocity_mode_pkg::OFS_INTERVAL, 32'h0);
		chk("stopped interval", 32'hfffff, rd);
		chk("hold scale", 32'd16, {27'h0, current_scale});
		bus(1'b1, velocity_mode_pkg::OFS_CTRL, CTRL_BASE | 32'h1);
		run <= 1'b1;
		run_at(8'd50, 8'h80, "quiet pwm");
		chk("irq masked", 32'h0, {31'h0, irq});
		bus(1'b1, velocity_mode_pkg::OFS_IRQ_MASK, 32'h1);
		repeat (3) @(posedge hclk);
		chk("irq raised", 32'h1, {31'h0, irq});
		bus(1'b1, velocity_mode_pkg::OFS_IRQ_STAT, 32'h7);
		repeat (3) @(posedge hclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		final_report();
	end
endmodule : velocity_mode_selector_tb
`default_nettype wire
